// *** rtl/pci_power_state_wake_control.sv ***
// Notes on behaviour
// R1 - Wake request only possible while the wake signal enable bit is set.
// R2 - Wake event sets the wake flag; writing one to it clears it.
// R3 - Wake request stays asserted while both flag and enable are one.
// R4 - Wake request behaves like a system interrupt line toward the host.
// R5 - Low-power state with enable clear means sleep mode, no wake signalling.
// R6 - Low-power state with enable set means wake-listening mode.
// R7 - Wake frame: valid frame holding six FF bytes then sixteen own addresses.
// R8 - With enable set, frames must pass receive filter and wake filter.
// R9 - Host keeps enable clear in normal operation to avoid rejecting frames.
// R10 - Power states D0, D1, D2, D3hot, D3cold, increasing power saving.
// R11 - In D1 only configuration access; no DMA or interrupts; reception continues.
// R12 - In D3hot, enable clear or no wake conditions turns the PHY off.
// R13 - Leaving D3hot resets configuration except enable and wake flag.
// R14 - Clearing enable deasserts the wake request.
// R15 - PHY powered in D0-D2; in D3 only with enable and wake conditions.
// R16 - Normal mode in D0; D2 and D3hot tolerate a stopped clock.
`timescale 1ns/1ns
`default_nettype none

module pci_power_state_wake_control (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_reg_write,
  input wire logic i_reg_read,
  input wire logic [7:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  output logic [31:0] o_reg_rdata,
  input wire logic i_aux_power_lost,
  input wire logic i_frame_start,
  input wire logic i_byte_valid,
  input wire logic [7:0] i_byte,
  input wire logic i_frame_end,
  input wire logic i_frame_good,
  input wire logic i_rx_filter_pass,
  input wire logic i_wake_filter_pass,
  input wire logic i_phy_event,
  input wire logic [47:0] i_station_address,
  input wire logic i_config_cycle,
  output logic o_frame_accept,
  output logic o_wake_request_out_n,
  output logic o_phy_power_on,
  output logic o_config_reset,
  output logic o_dma_allowed,
  output logic o_interrupt_allowed,
  output logic o_config_respond,
  output logic o_clock_may_stop,
  output logic [1:0] o_power_mode
);

  logic [31:0] wake_command_status;
  logic [31:0] next_wake_command_status;
  logic [31:0] receive_filter_control;
  logic [31:0] next_receive_filter_control;
  logic [1:0] power_state;
  logic [1:0] next_power_state;
  logic wake_signal_enable;
  logic next_wake_signal_enable;
  logic wake_event_flag;
  logic next_wake_event_flag;
  logic [31:0] next_reg_rdata;
  logic next_frame_accept;
  logic next_wake_request;
  logic next_phy_power_on;
  logic next_config_reset;
  logic next_dma_allowed;
  logic next_interrupt_allowed;
  logic next_config_respond;
  logic next_clock_may_stop;
  power_wake_pkg::power_mode_type mode;
  logic wake_conditions;
  logic pattern_seen;
  logic pattern_frame_wake;
  logic wake_event;
  logic write_power;
  logic leave_d3;
  logic [31:0] power_word;
  logic aux_lost_meta;
  logic aux_lost_sync;
  logic wake_armed;

  wake_frame_detect frame_scan (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_frame_start(i_frame_start),
    .i_byte_valid(i_byte_valid),
    .i_byte(i_byte),
    .i_station_address(i_station_address),
    .o_pattern_seen(pattern_seen)
  );

  // Aux supply sense comes from outside the clock domain
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      aux_lost_meta <= 1'b0;
      aux_lost_sync <= 1'b0;
    end else begin
      aux_lost_meta <= i_aux_power_lost;
      aux_lost_sync <= aux_lost_meta;
    end
  end

  // Register decode
  assign write_power = i_reg_write && i_reg_addr == power_wake_pkg::POWER_CTRL_OFFSET;
  assign wake_conditions = |wake_command_status;

  // PHY may stay up in D3 only while a wake can still be reported
  assign wake_armed = wake_signal_enable && wake_conditions &&
    receive_filter_control[power_wake_pkg::RX_FILTER_ENABLE_BIT] && !aux_lost_sync; // R12 R15

  // Pattern only counts once the frame ends good and passes both filters
  assign pattern_frame_wake = i_frame_end && i_frame_good && pattern_seen &&
    i_rx_filter_pass && i_wake_filter_pass; // R7 R8
  assign wake_event = (mode == power_wake_pkg::MODE_WAKE_LISTEN) &&
    (pattern_frame_wake || (i_phy_event && wake_conditions)); // R5 R6

  always_comb begin
    mode = power_wake_pkg::MODE_NORMAL; // R16
    if (power_state != power_wake_pkg::STATE_D0) begin
      mode = wake_signal_enable ? power_wake_pkg::MODE_WAKE_LISTEN
                                : power_wake_pkg::MODE_SLEEP; // R5 R6 R10
    end
  end

  // Only a write leaves D3; D3cold ends through reset
  assign leave_d3 = write_power && power_state == power_wake_pkg::STATE_D3 &&
    i_reg_wdata[power_wake_pkg::POWER_STATE_LSB +: 2] != power_wake_pkg::STATE_D3;

  always_comb begin
    next_wake_command_status = wake_command_status;
    next_receive_filter_control = receive_filter_control;
    next_power_state = power_state;
    next_wake_signal_enable = wake_signal_enable;
    next_wake_event_flag = wake_event_flag;
    if (i_reg_write && i_reg_addr == power_wake_pkg::WAKE_CMD_STATUS_OFFSET) begin
      next_wake_command_status = i_reg_wdata;
    end
    if (i_reg_write && i_reg_addr == power_wake_pkg::RX_FILTER_OFFSET) begin
      next_receive_filter_control = i_reg_wdata;
    end
    if (write_power) begin
      next_power_state = i_reg_wdata[power_wake_pkg::POWER_STATE_LSB +: 2];
      next_wake_signal_enable = i_reg_wdata[power_wake_pkg::WAKE_ENABLE_BIT]; // R14
      if (i_reg_wdata[power_wake_pkg::WAKE_FLAG_BIT]) begin
        next_wake_event_flag = 1'b0; // R2
      end
    end
    // A same-cycle event beats the write-one clear
    if (wake_event) begin
      next_wake_event_flag = 1'b1; // R2
    end
    if (leave_d3) begin
      next_wake_command_status = power_wake_pkg::WAKE_CMD_STATUS_RESET; // R13
      next_receive_filter_control = power_wake_pkg::RX_FILTER_RESET;
      next_power_state = power_wake_pkg::POWER_STATE_RESET;
    end
  end

  always_comb begin
    power_word = 32'h0000_0000;
    power_word[power_wake_pkg::POWER_STATE_LSB +: 2] = power_state;
    power_word[power_wake_pkg::WAKE_ENABLE_BIT] = wake_signal_enable;
    power_word[power_wake_pkg::WAKE_FLAG_BIT] = wake_event_flag;
    next_reg_rdata = o_reg_rdata;
    if (i_reg_read) begin
      case (i_reg_addr)
        power_wake_pkg::WAKE_CMD_STATUS_OFFSET: next_reg_rdata = wake_command_status;
        power_wake_pkg::POWER_CTRL_OFFSET: next_reg_rdata = power_word;
        power_wake_pkg::RX_FILTER_OFFSET: next_reg_rdata = receive_filter_control;
        default: next_reg_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_comb begin
    // Follows the next flag so a clear or enable drop acts the same edge
    next_wake_request = next_wake_event_flag && next_wake_signal_enable; // R1 R3 R4 R14
    next_frame_accept = i_frame_end && i_frame_good && i_rx_filter_pass &&
      (!wake_signal_enable || i_wake_filter_pass); // R8 R9 R11
    next_phy_power_on = (power_state != power_wake_pkg::STATE_D3) || wake_armed; // R12 R15
    next_config_reset = leave_d3; // R13
    next_dma_allowed = power_state == power_wake_pkg::STATE_D0; // R11
    next_interrupt_allowed = power_state == power_wake_pkg::STATE_D0; // R11
    next_config_respond = i_config_cycle; // R11
    next_clock_may_stop = power_state == power_wake_pkg::STATE_D2 ||
      power_state == power_wake_pkg::STATE_D3; // R16
  end

  // Every output leaves from a flip-flop
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wake_command_status <= power_wake_pkg::WAKE_CMD_STATUS_RESET;
      receive_filter_control <= power_wake_pkg::RX_FILTER_RESET;
      power_state <= power_wake_pkg::POWER_STATE_RESET;
      wake_signal_enable <= 1'b0;
      wake_event_flag <= 1'b0;
      o_reg_rdata <= 32'h0000_0000;
      o_frame_accept <= 1'b0;
      o_wake_request_out_n <= 1'b1;
      o_phy_power_on <= 1'b1;
      o_config_reset <= 1'b0;
      o_dma_allowed <= 1'b1;
      o_interrupt_allowed <= 1'b1;
      o_config_respond <= 1'b0;
      o_clock_may_stop <= 1'b0;
      o_power_mode <= 2'h0;
    end else begin
      wake_command_status <= next_wake_command_status;
      receive_filter_control <= next_receive_filter_control;
      power_state <= next_power_state;
      wake_signal_enable <= next_wake_signal_enable;
      wake_event_flag <= next_wake_event_flag;
      o_reg_rdata <= next_reg_rdata;
      o_frame_accept <= next_frame_accept;
      o_wake_request_out_n <= !next_wake_request;
      o_phy_power_on <= next_phy_power_on;
      o_config_reset <= next_config_reset;
      o_dma_allowed <= next_dma_allowed;
      o_interrupt_allowed <= next_interrupt_allowed;
      o_config_respond <= next_config_respond;
      o_clock_may_stop <= next_clock_may_stop;
      o_power_mode <= mode;
    end
  end

endmodule // pci_power_state_wake_control

`default_nettype wire

// *** rtl/power_wake_pkg.sv ***
package power_wake_pkg;

  localparam logic [7:0] WAKE_CMD_STATUS_OFFSET = 8'h40;
  localparam logic [7:0] POWER_CTRL_OFFSET = 8'h44;
  localparam logic [7:0] RX_FILTER_OFFSET = 8'h48;

  localparam int POWER_STATE_LSB = 0;
  localparam int WAKE_ENABLE_BIT = 8;
  localparam int WAKE_FLAG_BIT = 15;
  localparam int RX_FILTER_ENABLE_BIT = 31;

  localparam logic [31:0] WAKE_CMD_STATUS_RESET = 32'h0000_0000;
  localparam logic [31:0] RX_FILTER_RESET = 32'h0000_0000;
  localparam logic [1:0] POWER_STATE_RESET = 2'h0;

  localparam logic [1:0] STATE_D0 = 2'h0;
  localparam logic [1:0] STATE_D1 = 2'h1;
  localparam logic [1:0] STATE_D2 = 2'h2;
  localparam logic [1:0] STATE_D3 = 2'h3;

  localparam int SYNC_BYTES = 6;
  localparam int ADDR_COPIES = 16;
  localparam int ADDR_BYTES = 6;
  localparam logic [7:0] SYNC_VALUE = 8'hFF;

  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_SLEEP,
    MODE_WAKE_LISTEN
  } power_mode_type;

endpackage

// *** rtl/wake_frame_detect.sv ***
`timescale 1ns/1ns
`default_nettype none

module wake_frame_detect (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_frame_start,
  input wire logic i_byte_valid,
  input wire logic [7:0] i_byte,
  input wire logic [47:0] i_station_address,
  output logic o_pattern_seen
);

  typedef enum logic [1:0] {
    SCAN_SYNC,
    SCAN_ADDR,
    SCAN_DONE
  } scan_type;

  scan_type state;
  scan_type next_state;
  logic [2:0] sync_count;
  logic [2:0] next_sync_count;
  logic [2:0] byte_index;
  logic [2:0] next_byte_index;
  logic [4:0] copy_count;
  logic [4:0] next_copy_count;
  logic next_pattern_seen;
  logic [7:0] expected;

  // Address bytes go out first byte in the low bits
  assign expected = i_station_address[8*byte_index +: 8];

  always_comb begin
    next_state = state;
    next_sync_count = sync_count;
    next_byte_index = byte_index;
    next_copy_count = copy_count;
    next_pattern_seen = o_pattern_seen;
    if (i_frame_start) begin
      next_state = SCAN_SYNC;
      next_sync_count = 3'h0;
      next_byte_index = 3'h0;
      next_copy_count = 5'h00;
      next_pattern_seen = 1'b0;
    end else if (i_byte_valid) begin
      case (state)
        SCAN_SYNC: begin
          if (i_byte == power_wake_pkg::SYNC_VALUE) begin
            if (sync_count == 3'(power_wake_pkg::SYNC_BYTES - 1)) begin
              next_state = SCAN_ADDR;
            end else begin
              next_sync_count = sync_count + 3'h1;
            end
          end else begin
            next_sync_count = 3'h0;
          end
        end
        SCAN_ADDR: begin
          if (i_byte == expected) begin
            next_sync_count = 3'h0;
            if (byte_index == 3'(power_wake_pkg::ADDR_BYTES - 1)) begin
              next_byte_index = 3'h0;
              if (copy_count == 5'(power_wake_pkg::ADDR_COPIES - 1)) begin
                next_state = SCAN_DONE; // R7
                next_pattern_seen = 1'b1;
              end else begin
                next_copy_count = copy_count + 5'h01;
              end
            end else begin
              next_byte_index = byte_index + 3'h1;
            end
          end else if (i_byte == power_wake_pkg::SYNC_VALUE && byte_index == 3'h0 &&
                       copy_count == 5'h00) begin
            // Extra sync bytes: run of FF longer than six still qualifies
            next_state = SCAN_ADDR;
          end else begin
            // Restart; this byte may begin a new sync run
            next_state = SCAN_SYNC;
            next_byte_index = 3'h0;
            next_copy_count = 5'h00;
            next_sync_count = (i_byte == power_wake_pkg::SYNC_VALUE) ? 3'h1 : 3'h0;
          end
        end
        SCAN_DONE: begin
          next_state = SCAN_DONE;
        end
        default: begin
          next_state = SCAN_SYNC;
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= SCAN_SYNC;
      sync_count <= 3'h0;
      byte_index <= 3'h0;
      copy_count <= 5'h00;
      o_pattern_seen <= 1'b0;
    end else begin
      state <= next_state;
      sync_count <= next_sync_count;
      byte_index <= next_byte_index;
      copy_count <= next_copy_count;
      o_pattern_seen <= next_pattern_seen;
    end
  end

endmodule // wake_frame_detect

`default_nettype wire

// *** verif/pci_wake_asserts.sv ***
`timescale 1ns/1ns
`default_nettype none
module pci_wake_asserts (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_reg_write,
  input wire logic [7:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_frame_end,
  input wire logic i_frame_good,
  input wire logic i_rx_filter_pass,
  input wire logic i_wake_filter_pass,
  input wire logic i_phy_event,
  input wire logic o_frame_accept,
  input wire logic o_wake_request_out_n,
  input wire logic o_phy_power_on,
  input wire logic o_config_reset,
  input wire logic [1:0] o_power_mode
);
  logic en, next_en, pw;
  logic [1:0] st, next_st;
  assign pw = i_reg_write && i_reg_addr == power_wake_pkg::POWER_CTRL_OFFSET;
  // Mirror of enable and power state
  always_comb begin
    next_en = en;
    next_st = st;
    if (pw) begin
      next_en = i_reg_wdata[8];
      next_st = (st == 2'h3 && i_reg_wdata[1:0] != 2'h3) ? 2'h0 : i_reg_wdata[1:0];
    end
  end
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      en <= 1'b0;
      st <= 2'h0;
    end else begin
      en <= next_en;
      st <= next_st;
    end
  end
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  a_wake_needs_enable: assert property (
    $fell(o_wake_request_out_n) |-> en) else $error("wake request without enable");
  a_flag_write_clear: assert property (
    (pw && i_reg_wdata[15] && !i_frame_end && !i_phy_event) |=> o_wake_request_out_n)
    else $error("flag clear did not release wake request");
  a_wake_holds: assert property (
    (!o_wake_request_out_n && !pw) |=> !o_wake_request_out_n) else $error("wake request dropped");
  a_enable_clear_release: assert property (
    (pw && !i_reg_wdata[8]) |=> o_wake_request_out_n) else $error("wake request kept");
  a_sleep_mode: assert property (
    (pw && !i_reg_wdata[8] && st != 2'h3 && i_reg_wdata[1:0] != 2'h0)
    |-> ##[1:2] o_power_mode == 2'h1) else $error("sleep mode not entered");
  a_listen_mode: assert property (
    (pw && i_reg_wdata[8] && st != 2'h3 && i_reg_wdata[1:0] != 2'h0)
    |-> ##[1:2] o_power_mode == 2'h2) else $error("listening mode not entered");
  a_accept_both_filters: assert property (
    (i_frame_end && i_frame_good && i_rx_filter_pass && !pw)
    |=> o_frame_accept == (!$past(en) || $past(i_wake_filter_pass)))
    else $error("frame accept wrong");
  a_phy_off_sleep: assert property (
    (pw && st != 2'h3 && i_reg_wdata[1:0] == 2'h3 && !i_reg_wdata[8])
    |-> ##[1:2] !o_phy_power_on) else $error("phy left on");
  a_config_reset_exit: assert property (
    (pw && st == 2'h3 && i_reg_wdata[1:0] != 2'h3) |=> o_config_reset)
    else $error("no configuration reset");
  a_phy_on_awake: assert property (
    (st != 2'h3) |=> o_phy_power_on) else $error("phy off outside D3");
endmodule // pci_wake_asserts
bind pci_power_state_wake_control pci_wake_asserts u_chk (.i_sys_clk, .i_rst_n, .i_reg_write,
  .i_reg_addr, .i_reg_wdata, .i_frame_end, .i_frame_good, .i_rx_filter_pass,
  .i_wake_filter_pass, .i_phy_event, .o_frame_accept, .o_wake_request_out_n,
  .o_phy_power_on, .o_config_reset, .o_power_mode);
`default_nettype wire

// *** verif/pci_host_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module pci_host_model (
  input wire logic i_sys_clk,
  input wire logic [31:0] i_rdata,
  output logic o_write,
  output logic o_read,
  output logic [7:0] o_addr,
  output logic [31:0] o_wdata
);
  initial begin
    o_write = 1'b0;
    o_read = 1'b0;
    o_addr = 8'h0;
    o_wdata = 32'h0;
  end
  task automatic write_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    o_write <= 1'b1;
    o_addr <= a;
    o_wdata <= d;
    @(posedge i_sys_clk);
    o_write <= 1'b0;
    o_wdata <= ~d;
  endtask
  task automatic read_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_sys_clk);
    o_read <= 1'b1;
    o_addr <= a;
    @(posedge i_sys_clk);
    o_read <= 1'b0;
    @(negedge i_sys_clk);
    d = i_rdata;
  endtask
endmodule // pci_host_model
`default_nettype wire

// *** verif/pci_power_state_wake_control_tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module pci_power_state_wake_control_tb_top;
  localparam logic [47:0] STATION = 48'h0A1B2C3D4E5F;
  logic i_sys_clk, i_rst_n, i_reg_write, i_reg_read, i_frame_start, i_byte_valid, i_frame_end;
  logic i_frame_good, i_rx_filter_pass, i_wake_filter_pass, i_phy_event, i_config_cycle;
  logic o_frame_accept, o_wake_request_out_n, o_phy_power_on, o_config_reset, o_dma_allowed;
  logic o_interrupt_allowed, o_config_respond, o_clock_may_stop, i_aux_power_lost;
  logic [1:0] o_power_mode;
  logic [7:0] i_reg_addr, i_byte;
  logic [31:0] i_reg_wdata, o_reg_rdata, rd;
  int fail_count = 0;
  int checks_done = 0;
  int cycles = 0;
  pci_power_state_wake_control uut (.i_sys_clk, .i_rst_n, .i_reg_write, .i_reg_read,
    .i_reg_addr, .i_reg_wdata, .o_reg_rdata, .i_aux_power_lost, .i_frame_start,
    .i_byte_valid, .i_byte, .i_frame_end, .i_frame_good, .i_rx_filter_pass,
    .i_wake_filter_pass, .i_phy_event, .i_station_address(STATION), .i_config_cycle,
    .o_frame_accept, .o_wake_request_out_n, .o_phy_power_on, .o_config_reset,
    .o_dma_allowed, .o_interrupt_allowed, .o_config_respond, .o_clock_may_stop, .o_power_mode);
  pci_host_model host (.i_sys_clk, .i_rdata(o_reg_rdata), .o_write(i_reg_write),
    .o_read(i_reg_read), .o_addr(i_reg_addr), .o_wdata(i_reg_wdata));
  initial begin
    i_sys_clk = 1'b0;
    forever #25 i_sys_clk = ~i_sys_clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("MISMATCH time=%0t got=%h expected=%h", $time, got, exp);
      fail_count++;
    end
  endtask
  task automatic end_of_test();
    if (fail_count == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic settle();
    repeat (3) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
  endtask
  task automatic pulse_phy();
    @(posedge i_sys_clk);
    i_phy_event <= 1'b1;
    @(posedge i_sys_clk);
    i_phy_event <= 1'b0;
    @(negedge i_sys_clk);
  endtask
  // Sync run then sixteen address copies, or filler bytes
  task automatic send_frame(input logic wake, input logic wkp);
    @(posedge i_sys_clk);
    i_frame_start <= 1'b1;
    @(posedge i_sys_clk);
    i_frame_start <= 1'b0;
    for (int n = 0; n < 102; n++) begin
      @(posedge i_sys_clk);
      i_byte_valid <= 1'b1;
      i_byte <= !wake ? 8'h55 : (n < 6) ? 8'hFF : STATION[((n - 6) % 6) * 8 +: 8];
    end
    @(posedge i_sys_clk);
    i_byte_valid <= 1'b0;
    i_frame_end <= 1'b1;
    i_frame_good <= 1'b1;
    i_rx_filter_pass <= 1'b1;
    i_wake_filter_pass <= wkp;
    @(posedge i_sys_clk);
    i_frame_end <= 1'b0;
    i_frame_good <= 1'b0;
    i_rx_filter_pass <= 1'b0;
    i_wake_filter_pass <= ~wkp;
    @(negedge i_sys_clk);
  endtask
  task automatic t_reset_values();
    for (int i = 0; i < 4; i++) begin
      host.read_reg(8'h40 + 8'(4 * i), rd);
      chk(rd, 32'h0);
    end
    chk(o_dma_allowed, 1'b1);
  endtask
  task automatic t_normal();
    send_frame(1'b0, 1'b0);
    chk(o_frame_accept, 1'b1);
    chk(o_wake_request_out_n, 1'b1);
  endtask
  task automatic t_sleep();
    host.write_reg(8'h40, 32'h1);
    host.write_reg(8'h44, 32'h3);
    settle();
    chk(o_power_mode, 2'h1);
    chk(o_phy_power_on, 1'b0);
    pulse_phy();
    settle();
    chk(o_wake_request_out_n, 1'b1);
    host.write_reg(8'h44, 32'h0);
    @(negedge i_sys_clk);
    chk(o_config_reset, 1'b1);
    host.read_reg(8'h40, rd);
    chk(rd, 32'h0);
  endtask
  task automatic t_listen_d1();
    host.write_reg(8'h40, 32'h1);
    host.write_reg(8'h44, 32'h101);
    settle();
    chk(o_power_mode, 2'h2);
    chk(o_dma_allowed, 1'b0);
    chk(o_interrupt_allowed, 1'b0);
    chk(o_phy_power_on, 1'b1);
    @(posedge i_sys_clk);
    i_config_cycle <= 1'b1;
    @(posedge i_sys_clk);
    i_config_cycle <= 1'b0;
    @(negedge i_sys_clk);
    chk(o_config_respond, 1'b1);
    pulse_phy();
    chk(o_wake_request_out_n, 1'b0);
    host.write_reg(8'h44, 32'h8001);
    @(negedge i_sys_clk);
    chk(o_wake_request_out_n, 1'b1);
    host.write_reg(8'h44, 32'h0);
    host.write_reg(8'h40, 32'h0);
  endtask
  task automatic t_wake_frame();
    host.write_reg(8'h48, 32'h80000000);
    host.write_reg(8'h40, 32'h200);
    host.write_reg(8'h44, 32'h8103);
    send_frame(1'b0, 1'b1);
    chk(o_frame_accept, 1'b1);
    chk(o_wake_request_out_n, 1'b1);
    send_frame(1'b1, 1'b0);
    chk(o_frame_accept, 1'b0);
    send_frame(1'b1, 1'b1);
    chk(o_wake_request_out_n, 1'b0);
    host.read_reg(8'h44, rd);
    chk(rd, 32'h8103);
    host.write_reg(8'h44, 32'h100);
    @(negedge i_sys_clk);
    chk(o_config_reset, 1'b1);
    chk(o_wake_request_out_n, 1'b0);
    host.read_reg(8'h48, rd);
    chk(rd, 32'h0);
    host.write_reg(8'h44, 32'h8000);
    @(negedge i_sys_clk);
    chk(o_wake_request_out_n, 1'b1);
  endtask
  task automatic t_d2();
    host.write_reg(8'h44, 32'h2);
    settle();
    chk(o_clock_may_stop, 1'b1);
    host.write_reg(8'h44, 32'h0);
    settle();
    chk(o_clock_may_stop, 1'b0);
  endtask
  task automatic t_phy_d3();
    host.write_reg(8'h48, 32'h80000000);
    host.write_reg(8'h40, 32'h1);
    host.write_reg(8'h44, 32'h103);
    settle();
    chk(o_phy_power_on, 1'b1);
    @(posedge i_sys_clk);
    i_aux_power_lost <= 1'b1;
    settle();
    chk(o_phy_power_on, 1'b0);
    @(posedge i_sys_clk);
    i_aux_power_lost <= 1'b0;
    host.write_reg(8'h40, 32'h0);
    settle();
    chk(o_phy_power_on, 1'b0);
    host.write_reg(8'h44, 32'h0);
    settle();
    chk(o_phy_power_on, 1'b1);
  endtask
  always @(posedge i_sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fail_count++;
      end_of_test();
    end
  end
  initial begin
    i_rst_n = 1'b0;
    {i_frame_start, i_byte_valid, i_frame_end, i_frame_good, i_phy_event} = 5'h0;
    {i_rx_filter_pass, i_wake_filter_pass, i_config_cycle, i_aux_power_lost} = 4'h0;
    i_byte = 8'h0;
    repeat (20) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    t_reset_values();
    t_normal();
    t_sleep();
    t_listen_d1();
    t_wake_frame();
    t_d2();
    t_phy_d3();
    end_of_test();
  end
endmodule // pci_power_state_wake_control_tb_top
`default_nettype wire
